// ### src/amrs_pkg.sv
// Purpose: constants and types of the asynchronous memory read sequencer
// Assumes: 100 MHz interface clock, AXI4-Lite register access, 32-bit word requests
// Notes:   Summary of operation below, one line each
package amrs_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_IRQ_STAT   = 8'h00;
	localparam logic [7:0]  OFF_IRQ_SET    = 8'h04;
	localparam logic [7:0]  OFF_IRQ_CLR    = 8'h08;
	localparam logic [7:0]  OFF_SEQ_STATE  = 8'h0C;
	localparam logic [7:0]  OFF_CFG_BASE   = 8'h10;
	localparam int          NUM_REGIONS    = 4;
	// ----------------------------------------------------------------
	// region config fields and reset values
	// ----------------------------------------------------------------
	localparam int          CFG_SS_BIT     = 31;
	localparam int          CFG_EW_BIT     = 30;
	localparam int          CFG_SETUP_LSB  = 26;
	localparam int          CFG_STROBE_LSB = 20;
	localparam int          CFG_HOLD_LSB   = 17;
	localparam int          CFG_TA_LSB     = 2;
	localparam int          CFG_ASIZE_BIT  = 0;
	localparam logic [31:0] CFG_RST        = 32'h3FFF_FFFC;
	localparam int          IRQ_WR_BIT     = 0;
	localparam int          IRQ_TO_BIT     = 1;
	localparam logic [1:0]  IRQ_EN_RST     = 2'h0;
	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int          REQ_ADDR_W     = 24;
	localparam int          WADDR_W        = 22;
	localparam int          DATA_W         = 16;
	localparam logic [7:0]  WAIT_MAX_CYC   = 8'h40;
	localparam logic [1:0]  LAST_IDX_8     = 2'h3;
	localparam logic [1:0]  LAST_IDX_16    = 2'h1;
	localparam logic [1:0]  AXI_OKAY       = 2'h0;
	localparam logic [1:0]  AXI_SLVERR     = 2'h2;

	typedef enum logic [2:0] {S_IDLE, S_TURN, S_SETUP, S_STROBE, S_HOLD} amrs_state_t;

	// address of one external access unit, {word, bank}
	function automatic logic [REQ_ADDR_W-1:0] amrs_unit_addr(
		input logic [REQ_ADDR_W-1:0] addr,
		input logic                  asize,
		input logic [1:0]            idx);
		amrs_unit_addr = asize ? {1'b0, addr[REQ_ADDR_W-1:2], idx[0]}
		                       : {addr[REQ_ADDR_W-1:2], idx};
	endfunction
endpackage

// ### src/amrs_top.sv
// Purpose: normal-mode read sequencer for an external asynchronous memory
// Assumes: requesters hold valid until acked; data pins cross two flip-flops
// Notes:   requester 0 outranks requester 1; writes are sequenced elsewhere
`timescale 1ns/1ns
module amrs_top
	import amrs_pkg::*;
(
	// clock and reset
	input  wire logic                         CLK_SYS_I,
	input  wire logic                         RST_N_I,
	// axi4-lite register slave
	input  wire logic [7:0]                   S_AXI_AWADDR_I,
	input  wire logic                         S_AXI_AWVALID_I,
	output logic                              S_AXI_AWREADY_O,
	input  wire logic [31:0]                  S_AXI_WDATA_I,
	input  wire logic [3:0]                   S_AXI_WSTRB_I,
	input  wire logic                         S_AXI_WVALID_I,
	output logic                              S_AXI_WREADY_O,
	output logic [1:0]                        S_AXI_BRESP_O,
	output logic                              S_AXI_BVALID_O,
	input  wire logic                         S_AXI_BREADY_I,
	input  wire logic [7:0]                   S_AXI_ARADDR_I,
	input  wire logic                         S_AXI_ARVALID_I,
	output logic                              S_AXI_ARREADY_O,
	output logic [31:0]                       S_AXI_RDATA_O,
	output logic [1:0]                        S_AXI_RRESP_O,
	output logic                              S_AXI_RVALID_O,
	input  wire logic                         S_AXI_RREADY_I,
	output logic                              IRQ_O,
	// on-chip read requesters and the write-done input
	input  wire logic [1:0]                   REQ_VALID_I,
	input  wire logic [2*REQ_ADDR_W-1:0]      REQ_ADDR_I,
	input  wire logic [3:0]                   REQ_REGION_I,
	output logic [1:0]                        REQ_ACK_O,
	output logic [31:0]                       REQ_RDATA_O,
	input  wire logic                         WRITE_DONE_I,
	// external memory pins
	output logic [WADDR_W-1:0]                WORD_ADDR_PINS_O,
	output logic [1:0]                        BANK_ADDR_PINS_O,
	output logic [NUM_REGIONS-1:0]            REGION_SELECTS_N_O,
	output logic                              OUTPUT_ENABLE_N_O,
	output logic                              WRITE_STROBE_N_O,
	output logic [1:0]                        BYTE_ENABLE_PINS_O,
	input  wire logic [DATA_W-1:0]            DATA_PINS_I,
	input  wire logic                         WAIT_INPUT_I
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] data_s1_r, data_s2_r;
	logic              wait_s1_r, wait_s2_r, wait_s3_r;

	// stage 3 only feeds the wait-rise edge detector
	always_ff @(posedge CLK_SYS_I)
	begin
		data_s1_r <= DATA_PINS_I;
		data_s2_r <= data_s1_r;
		wait_s1_r <= WAIT_INPUT_I;
		wait_s2_r <= wait_s1_r;
		wait_s3_r <= wait_s2_r;
	end

	// ----------------------------------------------------------------
	// register file and axi4-lite slave
	// ----------------------------------------------------------------
	logic [31:0] cfg_r [NUM_REGIONS];
	logic [31:0] cfg_nxt [NUM_REGIONS];
	logic [1:0]  en_r, en_nxt, stat_r, stat_nxt;
	logic        irq_r, irq_nxt;
	logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, bvld_r, bvld_nxt;
	logic        arrdy_r, arrdy_nxt, rvld_r, rvld_nxt;
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0]  awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [1:0]  ev_set;           // events from the sequencer
	logic        busy_flag, last_rd_r, last_wr_r;
	amrs_state_t st_r, st_nxt;

	// hardware sets win over software clears
	always_comb
	begin
		cfg_nxt    = cfg_r;
		en_nxt     = en_r;
		stat_nxt   = stat_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		awa_nxt    = awa_r;
		wd_nxt     = wd_r;
		bvld_nxt   = bvld_r && !S_AXI_BREADY_I;
		bresp_nxt  = bresp_r;
		rvld_nxt   = rvld_r && !S_AXI_RREADY_I;
		rresp_nxt  = rresp_r;
		rd_nxt     = rd_r;
		if (S_AXI_AWVALID_I && awrdy_r)
		begin
			aw_got_nxt = 1'b1;
			awa_nxt    = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && wrdy_r)
		begin
			w_got_nxt = 1'b1;
			wd_nxt    = S_AXI_WDATA_I; // strobes ignored, full-word registers
		end
		if (aw_got_r && w_got_r && !bvld_r)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvld_nxt   = 1'b1;
			bresp_nxt  = AXI_OKAY;
			case (awa_r[7:2])
				OFF_IRQ_STAT[7:2]: stat_nxt = stat_r & ~wd_r[1:0];
				OFF_IRQ_SET[7:2]:  en_nxt = en_r | wd_r[1:0];
				OFF_IRQ_CLR[7:2]:  en_nxt = en_r & ~wd_r[1:0];
				default:
				begin
					if (awa_r >= OFF_CFG_BASE && awa_r < OFF_CFG_BASE + 8'h10)
						cfg_nxt[awa_r[3:2]] = wd_r;
					else
						bresp_nxt = AXI_SLVERR;
				end
			endcase
		end
		stat_nxt = stat_nxt | ev_set;
		awrdy_nxt = !aw_got_nxt && !bvld_nxt;
		wrdy_nxt  = !w_got_nxt && !bvld_nxt;
		if (S_AXI_ARVALID_I && arrdy_r)
		begin
			rvld_nxt  = 1'b1;
			rresp_nxt = AXI_OKAY;
			case (S_AXI_ARADDR_I[7:2])
				OFF_IRQ_STAT[7:2]:  rd_nxt = {30'h0, stat_r};
				OFF_IRQ_SET[7:2],
				OFF_IRQ_CLR[7:2]:   rd_nxt = {30'h0, en_r};
				OFF_SEQ_STATE[7:2]: rd_nxt = {27'h0, last_wr_r, last_rd_r, busy_flag, 2'h0};
				default:
				begin
					if (S_AXI_ARADDR_I >= OFF_CFG_BASE && S_AXI_ARADDR_I < OFF_CFG_BASE + 8'h10)
						rd_nxt = cfg_r[S_AXI_ARADDR_I[3:2]];
					else
					begin
						rd_nxt    = 32'h0000_0000;
						rresp_nxt = AXI_SLVERR;
					end
				end
			endcase
		end
		arrdy_nxt = !rvld_nxt;
		// level interrupt while any enabled status bit is set
		irq_nxt = |(stat_nxt & en_nxt);
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			cfg_r    <= '{default: CFG_RST};
			en_r     <= IRQ_EN_RST;
			stat_r   <= 2'h0;
			irq_r    <= 1'b0;
			awrdy_r  <= 1'b0;
			wrdy_r   <= 1'b0;
			bvld_r   <= 1'b0;
			arrdy_r  <= 1'b0;
			rvld_r   <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awa_r    <= 8'h00;
			wd_r     <= 32'h0000_0000;
			rd_r     <= 32'h0000_0000;
			bresp_r  <= AXI_OKAY;
			rresp_r  <= AXI_OKAY;
		end
		else
		begin
			cfg_r    <= cfg_nxt;
			en_r     <= en_nxt;
			stat_r   <= stat_nxt;
			irq_r    <= irq_nxt;
			awrdy_r  <= awrdy_nxt;
			wrdy_r   <= wrdy_nxt;
			bvld_r   <= bvld_nxt;
			arrdy_r  <= arrdy_nxt;
			rvld_r   <= rvld_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			awa_r    <= awa_nxt;
			wd_r     <= wd_nxt;
			rd_r     <= rd_nxt;
			bresp_r  <= bresp_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read sequencer
	// ----------------------------------------------------------------
	logic                  cur_r, cur_nxt, win;
	logic [31:0]           lcfg_r, lcfg_nxt, ccfg;
	logic [REQ_ADDR_W-1:0] addr_r, addr_nxt, unit;
	logic [1:0]            reg_r, reg_nxt, idx_r, idx_nxt, last_idx, ta;
	logic [5:0]            cnt_r, cnt_nxt;
	logic [7:0]            wcnt_r, wcnt_nxt;
	logic [31:0]           data_r, data_nxt;
	logic [1:0]            ack_r, ack_nxt, be_r, be_nxt;
	logic [3:0]            cs_r, cs_nxt;
	logic                  oe_r, oe_nxt, last_rd_nxt, last_wr_nxt, go_setup, lcl_wait;
	logic [WADDR_W-1:0]    wa_r, wa_nxt;
	logic [1:0]            ba_r, ba_nxt;

	assign win       = !REQ_VALID_I[0];                   // requester 0 first
	assign busy_flag = (st_r != S_IDLE);
	assign last_idx  = lcfg_r[CFG_ASIZE_BIT] ? LAST_IDX_16 : LAST_IDX_8;
	assign lcl_wait  = lcfg_r[CFG_EW_BIT] && wait_s2_r;

	always_comb
	begin
		st_nxt      = st_r;
		cur_nxt     = cur_r;
		lcfg_nxt    = lcfg_r;
		addr_nxt    = addr_r;
		reg_nxt     = reg_r;
		idx_nxt     = idx_r;
		cnt_nxt     = cnt_r;
		wcnt_nxt    = wcnt_r;
		data_nxt    = data_r;
		ack_nxt     = 2'h0;
		cs_nxt      = cs_r;
		oe_nxt      = oe_r;
		be_nxt      = be_r;
		wa_nxt      = wa_r;
		ba_nxt      = ba_r;
		last_rd_nxt = last_rd_r;
		last_wr_nxt = last_wr_r;
		go_setup    = 1'b0;
		ev_set      = 2'h0;
		ccfg        = cfg_r[REQ_REGION_I[{win, 1'b1} -: 2]];
		ta          = ccfg[CFG_TA_LSB +: 2];
		if (wait_s2_r && !wait_s3_r)
			ev_set[IRQ_WR_BIT] = 1'b1;
		if (WRITE_DONE_I)
		begin
			last_wr_nxt = 1'b1;
			last_rd_nxt = 1'b0;
		end
		case (st_r)
			S_IDLE:
			begin
				if (|REQ_VALID_I)
				begin
					cur_nxt  = win;
					lcfg_nxt = ccfg;
					reg_nxt  = REQ_REGION_I[{win, 1'b1} -: 2];
					addr_nxt = REQ_ADDR_I[win*REQ_ADDR_W +: REQ_ADDR_W];
					idx_nxt  = 2'h0;
					if (last_rd_r)
						go_setup = 1'b1;
					else if (last_wr_r && ta == 2'h0)
					begin
						st_nxt  = S_TURN;                 // one forced cycle
						cnt_nxt = 6'h00;
					end
					else if (ta == 2'h0)
						go_setup = 1'b1;
					else
					begin
						st_nxt  = S_TURN;
						cnt_nxt = {4'h0, ta} - 6'h01;
					end
				end
			end
			S_TURN:
			begin
				if (cnt_r != 6'h00)
					cnt_nxt = cnt_r - 6'h01;
				else if (REQ_VALID_I[cur_r] && win == cur_r)
					go_setup = 1'b1;
				else
					st_nxt = S_IDLE;                      // abandoned
			end
			S_SETUP:
			begin
				if (cnt_r != 6'h00)
					cnt_nxt = cnt_r - 6'h01;
				else
				begin
					st_nxt   = S_STROBE;
					cnt_nxt  = lcfg_r[CFG_STROBE_LSB +: 6];
					wcnt_nxt = 8'h00;
					oe_nxt   = 1'b0;
				end
			end
			S_STROBE:
			begin
				if (cnt_r != 6'h00)
					cnt_nxt = cnt_r - 6'h01;
				else if (lcl_wait && wcnt_r != WAIT_MAX_CYC)
					wcnt_nxt = wcnt_r + 8'h01;            // memory stretches strobe
				else
				begin
					if (lcl_wait)
						ev_set[IRQ_TO_BIT] = 1'b1;
					st_nxt  = S_HOLD;
					cnt_nxt = {3'h0, lcfg_r[CFG_HOLD_LSB +: 3]};
					oe_nxt  = 1'b1;                       // sample on this edge
					if (lcfg_r[CFG_ASIZE_BIT])
						data_nxt[{idx_r[0], 4'h0} +: 16] = data_s2_r;
					else
						data_nxt[{idx_r, 3'h0} +: 8] = data_s2_r[7:0];
				end
			end
			S_HOLD:
			begin
				if (cnt_r != 6'h00)
					cnt_nxt = cnt_r - 6'h01;
				else if (idx_r != last_idx)
				begin
					idx_nxt  = idx_r + 2'h1;
					st_nxt   = S_SETUP;                   // same latched timing
					cnt_nxt  = {2'h0, lcfg_r[CFG_SETUP_LSB +: 4]};
					unit     = amrs_unit_addr(addr_r, lcfg_r[CFG_ASIZE_BIT], idx_nxt);
					wa_nxt   = unit[REQ_ADDR_W-1:2];
					ba_nxt   = unit[1:0];
				end
				else
				begin
					st_nxt      = S_IDLE;
					wa_nxt      = '0;
					ba_nxt      = 2'h0;
					cs_nxt      = 4'hF;
					be_nxt      = 2'h3;
					ack_nxt     = 2'h1 << cur_r;
					last_rd_nxt = 1'b1;
					last_wr_nxt = 1'b0;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		unit = amrs_unit_addr(addr_nxt, lcfg_nxt[CFG_ASIZE_BIT], 2'h0);
		if (go_setup)
		begin
			st_nxt  = S_SETUP;
			cnt_nxt = {2'h0, lcfg_nxt[CFG_SETUP_LSB +: 4]};
			wa_nxt  = unit[REQ_ADDR_W-1:2];
			ba_nxt  = unit[1:0];
			cs_nxt  = ~(4'h1 << reg_nxt);
			// byte enables only in normal mode
			be_nxt  = lcfg_nxt[CFG_SS_BIT] ? 2'h3 : 2'h0;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			st_r      <= S_IDLE;
			cur_r     <= 1'b0;
			lcfg_r    <= CFG_RST;
			addr_r    <= '0;
			reg_r     <= 2'h0;
			idx_r     <= 2'h0;
			cnt_r     <= 6'h00;
			wcnt_r    <= 8'h00;
			data_r    <= 32'h0000_0000;
			ack_r     <= 2'h0;
			cs_r      <= 4'hF;
			oe_r      <= 1'b1;
			be_r      <= 2'h3;
			wa_r      <= '0;
			ba_r      <= 2'h0;
			last_rd_r <= 1'b0;
			last_wr_r <= 1'b0;
		end
		else
		begin
			st_r      <= st_nxt;
			cur_r     <= cur_nxt;
			lcfg_r    <= lcfg_nxt;
			addr_r    <= addr_nxt;
			reg_r     <= reg_nxt;
			idx_r     <= idx_nxt;
			cnt_r     <= cnt_nxt;
			wcnt_r    <= wcnt_nxt;
			data_r    <= data_nxt;
			ack_r     <= ack_nxt;
			cs_r      <= cs_nxt;
			oe_r      <= oe_nxt;
			be_r      <= be_nxt;
			wa_r      <= wa_nxt;
			ba_r      <= ba_nxt;
			last_rd_r <= last_rd_nxt;
			last_wr_r <= last_wr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all registered except the tied-high write strobe
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY_O    = awrdy_r;
	assign S_AXI_WREADY_O     = wrdy_r;
	assign S_AXI_BVALID_O     = bvld_r;
	assign S_AXI_BRESP_O      = bresp_r;
	assign S_AXI_ARREADY_O    = arrdy_r;
	assign S_AXI_RVALID_O     = rvld_r;
	assign S_AXI_RDATA_O      = rd_r;
	assign S_AXI_RRESP_O      = rresp_r;
	assign IRQ_O              = irq_r;
	assign REQ_ACK_O          = ack_r;
	assign REQ_RDATA_O        = data_r;
	assign WORD_ADDR_PINS_O   = wa_r;
	assign BANK_ADDR_PINS_O   = ba_r;
	assign REGION_SELECTS_N_O = cs_r;
	assign OUTPUT_ENABLE_N_O  = oe_r;
	assign WRITE_STROBE_N_O   = 1'b1;                // reads never strobe
	assign BYTE_ENABLE_PINS_O = be_r;                // low-active lane enables

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	AST_WE_HIGH: assert property (busy_flag |-> WRITE_STROBE_N_O)
		else $error("write strobe low during read");
	AST_OE_STROBE: assert property (!OUTPUT_ENABLE_N_O |-> st_r == S_STROBE)
		else $error("output enable low outside strobe");
	AST_BE_NORMAL: assert property ((st_r == S_SETUP && !lcfg_r[CFG_SS_BIT]) |-> be_r == 2'h0)
		else $error("byte enables not active in normal mode");
	AST_MASK_CLR: assert property ((aw_got_r && w_got_r && !bvld_r && awa_r == OFF_IRQ_CLR
		&& wd_r[IRQ_WR_BIT]) |=> !en_r[IRQ_WR_BIT])
		else $error("wait-rise enable not cleared");
	AST_IRQ_GATE: assert property (!en_r[IRQ_TO_BIT] && !en_r[IRQ_WR_BIT] |-> !IRQ_O)
		else $error("interrupt raised while disabled");
	AST_NO_TURN: assert property ((st_r == S_IDLE && |REQ_VALID_I && last_rd_r) |=> st_r == S_SETUP)
		else $error("turnaround inserted after read");
	AST_ONE_TURN: assert property ((st_r == S_IDLE && |REQ_VALID_I && !last_rd_r && last_wr_r
		&& ta == 2'h0) |=> st_r == S_TURN ##1 st_r != S_TURN)
		else $error("read after write lacks one turnaround cycle");
	AST_CS_SETUP: assert property (st_r == S_SETUP |-> !cs_r[reg_r])
		else $error("region select high in setup");
	AST_SPLIT: assert property ((st_r == S_HOLD && cnt_r == 6'h00 && idx_r != last_idx)
		|=> st_r == S_SETUP && !cs_r[reg_r])
		else $error("split access did not re-enter setup");
	AST_CS_REL: assert property ((st_r == S_HOLD && cnt_r == 6'h00 && idx_r == last_idx)
		|=> cs_r == 4'hF && $rose(ack_r[cur_r]))
		else $error("select not released at request end");
endmodule // amrs_top

// ### test/amrs_mem_model.sv
// Purpose: behavioural async memory facing the read sequencer pins
// Assumes: data follows the address while any select is low
// Notes:   released bus shows the inverse of its last value
`timescale 1ns/1ns
module amrs_mem_model (
	// clock
	input  wire logic        clk_i,
	// pins from the sequencer, wait request from the bench
	input  wire logic [21:0] word_addr_i,
	input  wire logic [1:0]  bank_addr_i,
	input  wire logic [3:0]  selects_n_i,
	input  wire logic        wait_req_i,
	// pins to the sequencer
	output logic      [15:0] data_o,
	output logic             wait_o
);
	logic [15:0] last_r = 16'h5A5A;
	// remember the bus so a released bus cannot look valid
	always_ff @(posedge clk_i)
		last_r <= data_o;
	// content is the low unit address bits, valid while selected
	always_comb
		if (&selects_n_i)
			data_o = ~last_r;
		else
			data_o = {word_addr_i[13:0], bank_addr_i};
	assign wait_o = wait_req_i;
endmodule // amrs_mem_model

// ### test/tb_top.sv
// Purpose: self-checking bench of the read sequencer
// Assumes: one clock, AXI4-Lite register access
// Notes:   latencies are derived from the phase fields
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
	import amrs_pkg::*;
	logic        clk_sys = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, write_done = 0, wait_req = 0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [1:0]  req_valid = 2'h0;
	logic [47:0] req_addr = 48'h0;
	logic [3:0]  req_region = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq, oe_n, we_n, wait_pin;
	logic [1:0]  bresp, rresp, req_ack, baddr, be_n;
	logic [31:0] rdata, req_rdata, rd;
	logic [21:0] waddr;
	logic [3:0]  sel_n;
	logic [15:0] dpins;
	int          fail_count = 0, checks_done = 0;
	initial forever #5 clk_sys = ~clk_sys;
	amrs_top u_dut (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .IRQ_O(irq), .REQ_VALID_I(req_valid), .REQ_ADDR_I(req_addr),
		.REQ_REGION_I(req_region), .REQ_ACK_O(req_ack), .REQ_RDATA_O(req_rdata),
		.WRITE_DONE_I(write_done), .WORD_ADDR_PINS_O(waddr), .BANK_ADDR_PINS_O(baddr),
		.REGION_SELECTS_N_O(sel_n), .OUTPUT_ENABLE_N_O(oe_n), .WRITE_STROBE_N_O(we_n),
		.BYTE_ENABLE_PINS_O(be_n), .DATA_PINS_I(dpins), .WAIT_INPUT_I(wait_pin));
	amrs_mem_model u_mem (.clk_i(clk_sys), .word_addr_i(waddr), .bank_addr_i(baddr),
		.selects_n_i(sel_n), .wait_req_i(wait_req), .data_o(dpins), .wait_o(wait_pin));
	// pin watch: strobe idle on reads, output enable only inside a selected access
	always @(posedge clk_sys)
		if (rst_n)
		begin
			`CHK("we_n", 1'b1, we_n)
			if (oe_n === 1'b0)
			begin
				`CHK("sel_on_oe", 1'b1, ~&sel_n)
				`CHK("byte_en", 2'h0, be_n)
			end
		end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic stuck();
		fail_count++;
		report_and_stop();
	endtask
	// one write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (int i = 0; i < 60; i++)
		begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin r = bresp; bready <= 0; return; end
		end
		stuck();
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (int i = 0; i < 60; i++)
		begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin d = rdata; r = rresp; rready <= 0; return; end
		end
		stuck();
	endtask
	function automatic logic [31:0] cfg(int s, int st, int h, int ta, logic asz);
		return (s << CFG_SETUP_LSB) | (st << CFG_STROBE_LSB) | (h << CFG_HOLD_LSB)
			| (ta << CFG_TA_LSB) | asz;
	endfunction
	// expected word assembled from units, byte or halfword k at lane k
	function automatic logic [31:0] expd(logic [23:0] a, logic asz);
		logic [31:0] x;
		x = 32'h0;
		for (int k = 0; k < 4; k++)
			if (asz && k < 2) x[16*k +: 16] = {a[16:2], k[0]};
			else if (!asz) x[8*k +: 8] = {a[7:2], k[1:0]};
		return x;
	endfunction
	task automatic put_region(int n, logic [31:0] c);
		logic [1:0] r;
		axi_wr(OFF_CFG_BASE + 8'(4 * n), c, r);
		`CHK("cfg_resp", AXI_OKAY, r)
	endtask
	task automatic start(int w, logic [1:0] rg, logic [23:0] a);
		req_addr[24*w +: 24] <= a; req_region[2*w +: 2] <= rg; req_valid[w] <= 1'b1;
	endtask
	// counts edges to the ack, drops valid in the ack cycle, checks data and idle pins
	task automatic fin(int w, int lat, logic asz, logic [23:0] a);
		for (int n = 1; n < lat + 40; n++)
		begin
			@(posedge clk_sys);
			if (n == lat) req_valid[w] <= 1'b0;
			#1;
			if (req_ack[w] === 1'b1)
			begin
				`CHK("latency", lat, n)
				`CHK("rdata", expd(a, asz), req_rdata)
				`CHK("idle_sel", 4'hF, sel_n)
				`CHK("idle_addr", 22'h0, waddr)
				return;
			end
		end
		stuck();
	endtask
	task automatic wr_done();
		@(posedge clk_sys) write_done <= 1;
		@(posedge clk_sys) write_done <= 0;
	endtask
	task automatic t_regs();
		logic [1:0] r;
		axi_rd(OFF_CFG_BASE, rd, r);
		`CHK("cfg_reset", CFG_RST, rd)
		axi_rd(8'h40, rd, r);
		`CHK("unmapped", AXI_SLVERR, r)
		$display("test regs done");
	endtask
	// strobe field of one keeps pin data two edges ahead of the synchroniser output
	task automatic t_reads();
		put_region(1, cfg(0, 1, 0, 0, 1));
		start(0, 2'h1, 24'h01_2344); fin(0, 9, 1'b1, 24'h01_2344);
		put_region(1, cfg(0, 1, 0, 3, 1));
		start(0, 2'h1, 24'h00_5678); fin(0, 9, 1'b1, 24'h00_5678);
		put_region(2, cfg(1, 2, 1, 2, 0));
		start(1, 2'h2, 24'h00_00AC); fin(1, 29, 1'b0, 24'h00_00AC);
		$display("test reads done");
	endtask
	task automatic t_after_write();
		put_region(0, cfg(0, 1, 0, 0, 1));
		wr_done(); start(0, 2'h0, 24'h00_1110); fin(0, 10, 1'b1, 24'h00_1110);
		put_region(0, cfg(0, 1, 0, 2, 1));
		wr_done(); start(0, 2'h0, 24'h00_2220); fin(0, 11, 1'b1, 24'h00_2220);
		// requester 0 arrives during requester 1's turnaround: 1 is dropped, then re-served
		wr_done(); start(1, 2'h0, 24'h00_4440);
		@(posedge clk_sys) start(0, 2'h0, 24'h00_3330);
		fin(0, 13, 1'b1, 24'h00_3330);
		fin(1, 9, 1'b1, 24'h00_4440);
		$display("test after write done");
	endtask
	task automatic t_priority();
		put_region(3, cfg(0, 1, 0, 0, 1));
		start(1, 2'h3, 24'h00_0BB8); start(0, 2'h3, 24'h00_0AA4);
		fin(0, 9, 1'b1, 24'h00_0AA4);
		fin(1, 9, 1'b1, 24'h00_0BB8);
		$display("test priority done");
	endtask
	task automatic t_irq();
		logic [1:0] r;
		int i;
		axi_wr(OFF_IRQ_SET, 32'h3, r);
		@(posedge clk_sys) wait_req <= 1;
		repeat (4) @(posedge clk_sys);
		wait_req <= 0;
		for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk_sys);
		`CHK("irq_on", 1'b1, irq)
		axi_wr(OFF_IRQ_CLR, 32'h1, r);
		axi_rd(OFF_IRQ_SET, rd, r);
		`CHK("en_after_clr", 32'h2, rd)
		repeat (2) @(posedge clk_sys);
		`CHK("irq_masked", 1'b0, irq)
		// timeout still enabled: an access held by the wait pin must raise the interrupt
		put_region(1, cfg(0, 1, 0, 0, 1) | (32'h1 << CFG_EW_BIT));
		@(posedge clk_sys) wait_req <= 1;
		start(0, 2'h1, 24'h00_6660); fin(0, 137, 1'b1, 24'h00_6660);
		`CHK("irq_timeout", 1'b1, irq)
		axi_wr(OFF_IRQ_CLR, 32'h2, r);
		axi_rd(OFF_IRQ_CLR, rd, r);
		`CHK("en_none", 32'h0, rd)
		`CHK("irq_to_masked", 1'b0, irq)
		axi_rd(OFF_IRQ_STAT, rd, r);
		`CHK("stat_kept", 32'h3, rd)
		wait_req <= 0;
		axi_wr(OFF_IRQ_STAT, 32'h3, r);
		axi_rd(OFF_IRQ_STAT, rd, r);
		`CHK("stat_clr", 32'h0, rd)
		$display("test irq done");
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1;
		repeat (2) @(posedge clk_sys);
		t_regs();
		t_reads();
		t_after_write();
		t_priority();
		t_irq();
		report_and_stop();
	end
endmodule // tb_top
